// file: pkg/tfr_defines.svh
// Constants for the serial-drive task file register block.
//
// Operation
// - A bad flash block found during a command sets error bit 7.
// - An uncorrectable data error sets error bit 6.
// - A missing or invalid sector address sets error bit 4.
// - Abort on not ready, write fault or invalid command sets error bit 2.
// - Any other error sets error bit 0; bits 5, 3, 1 read zero.
// - A transfer count of zero means 256 sectors.
// - The transfer count reads zero after a successful command.
// - After a failed command the count holds the sectors still left.
// - Block address is byte0, byte1, byte2 and drive/head low nibble.
// - Drive/head bit 6 clear selects CHS, set selects block addressing.
// - Reading status clears a pending interrupt; auxiliary status does not.
// - While busy the device owns command register and buffer.
// - Ready stays clear from power up until commands can be accepted.
// - Data request is set while data must move through the data register.
// - Corrected data sets status bit 2 and multi-sector reads continue.
// - Status bit 0 flags an errored command; status bit 1 reads zero.
// - High-order select returns previous values; command block writes clear it.
// - Control bit 2 holds the drive in soft reset until written zero.
// - Control bit 1 masks interrupts; it clears at power on.
// - Drive address bit 6 reads zero while a write is in progress.
// - Drive address bits 5..2 are inverted drive/head bits 3..0.
`ifndef TFR_DEFINES_SVH
`define TFR_DEFINES_SVH

// -----------------------------------------------------------------------
// Register indices on the access port
// -----------------------------------------------------------------------
`define TFR_IDX_DATA     4'h0
`define TFR_IDX_ERROR    4'h1
`define TFR_IDX_COUNT    4'h2
`define TFR_IDX_ADDR0    4'h3
`define TFR_IDX_ADDR1    4'h4
`define TFR_IDX_ADDR2    4'h5
`define TFR_IDX_TARGET   4'h6
`define TFR_IDX_STATE    4'h7
`define TFR_IDX_AUX      4'h8
`define TFR_IDX_ECHO     4'h9

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define TFR_ERR_BAD_BLOCK   7
`define TFR_ERR_UNCORR      6
`define TFR_ERR_NOT_FOUND   4
`define TFR_ERR_ABORTED     2
`define TFR_ERR_GENERAL     0
`define TFR_TGT_LBA_MODE    6
`define TFR_CTL_HOB         7
`define TFR_CTL_SRST        2
`define TFR_CTL_IMASK       1

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define TFR_TARGET_RST      8'ha0
`define TFR_COUNT_RST       8'h01
`define TFR_ADDR0_RST       8'h01
`define TFR_SECTORS_MAX     9'h100

`endif

// file: pkg/tfr_pkg.sv
// Types shared by the task file register block.
package tfr_pkg;
    // Command phase of the drive
    typedef enum logic [1:0] {
        TFR_IDLE  = 2'b00,
        TFR_RUN   = 2'b01,
        TFR_SRST  = 2'b10
    } tfr_phase_t;

    typedef logic [7:0] tfr_byte_t;
endpackage

// file: logic/tfr_task_file.sv
// Task file register bank of a serial storage drive.
`timescale 1ns/100ps
`default_nettype none
`include "tfr_defines.svh"

module tfr_task_file (
    input  wire logic                clock,
    input  wire logic                rst_n,
    // Register access carried by the link frames
    input  wire logic                acc_valid,
    input  wire logic                acc_write,
    input  wire logic [3:0]          acc_addr,
    input  wire logic [15:0]         acc_wdata,
    output logic      [15:0]         acc_rdata,
    // Device-to-host register frame
    output logic                     frame_valid,
    output tfr_pkg::tfr_byte_t       frame_status,
    output tfr_pkg::tfr_byte_t       frame_error,
    output tfr_pkg::tfr_byte_t       frame_count,
    output logic                     drive_irq,
    // Drive core command side
    output logic                     core_cmd_start,
    output tfr_pkg::tfr_byte_t       core_cmd_code,
    output tfr_pkg::tfr_byte_t       core_features,
    output logic                     core_lba_mode,
    output logic      [27:0]         core_address,
    output logic      [8:0]          core_sector_total,
    output logic                     core_soft_reset,
    // Drive core reports
    input  wire logic                core_ready,
    input  wire logic                core_sector_done,
    input  wire logic                core_cmd_done,
    input  wire logic                core_cmd_fail,
    input  wire logic                core_bad_block,
    input  wire logic                core_uncorrectable,
    input  wire logic                core_not_found,
    input  wire logic                core_aborted,
    input  wire logic                core_general_error,
    input  wire logic                core_corrected,
    input  wire logic                core_write_fault,
    input  wire logic                core_write_active,
    input  wire logic                core_data_request,
    // Data register path
    input  wire logic [15:0]         core_rd_word,
    output logic                     core_rd_take,
    output logic      [15:0]         core_wr_word,
    output logic                     core_wr_put
);
    import tfr_pkg::*;

    // -------------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------------
    tfr_phase_t phase_reg;
    tfr_byte_t  error_reg;
    tfr_byte_t  feature_reg;
    tfr_byte_t  count_reg;
    tfr_byte_t  addr0_reg;
    tfr_byte_t  addr1_reg;
    tfr_byte_t  addr2_reg;
    tfr_byte_t  target_reg;
    tfr_byte_t  count_prev_reg;
    tfr_byte_t  addr0_prev_reg;
    tfr_byte_t  addr1_prev_reg;
    tfr_byte_t  addr2_prev_reg;
    tfr_byte_t  target_prev_reg;
    tfr_byte_t  command_reg;
    logic       hob_reg;
    logic       srst_reg;
    logic       imask_reg;
    logic       err_reg;
    logic       corrected_data_flag_reg;
    logic       fault_reg;
    logic       drq_reg;
    logic       wact_reg;
    logic       pend_reg;

    logic       wr_cmd_block;
    logic       wr_command;
    logic       wr_control;
    logic       rd_state;
    logic       finish;
    logic       busy;
    logic       ready;
    tfr_byte_t  state_byte;
    tfr_byte_t  echo_byte;

    // -------------------------------------------------------------------
    // Access decode
    // -------------------------------------------------------------------
    // Command block writes are refused while busy; control is always open
    assign busy = (phase_reg != TFR_IDLE) | srst_reg;
    assign wr_cmd_block = acc_valid & acc_write & ~busy
                        & (acc_addr >= `TFR_IDX_ERROR)
                        & (acc_addr <= `TFR_IDX_STATE);
    assign wr_command = wr_cmd_block & (acc_addr == `TFR_IDX_STATE);
    assign wr_control = acc_valid & acc_write & (acc_addr == `TFR_IDX_AUX);
    assign rd_state   = acc_valid & ~acc_write & (acc_addr == `TFR_IDX_STATE);
    assign finish     = (phase_reg == TFR_RUN) & (core_cmd_done | core_cmd_fail);

    // Ready is held low until the core says it can take commands
    assign ready = core_ready & ~srst_reg;

    // Status byte; bit 1 is the unused index flag and reads zero
    assign state_byte = {busy, ready, fault_reg, ready,
                         drq_reg, corrected_data_flag_reg, 1'b0, err_reg};

    // Drive address echo; only drive 0 exists, bit 7 reads zero
    assign echo_byte = {1'b0, ~wact_reg,
                        ~target_reg[3:0],
                        1'b1, 1'b0};

    // -------------------------------------------------------------------
    // Command phase
    // -------------------------------------------------------------------
    // Soft reset overrides everything; leaving it drops back to idle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_reg <= TFR_IDLE;
        end else if (srst_reg) begin
            phase_reg <= TFR_SRST;
        end else begin
            unique case (phase_reg)
                TFR_IDLE: begin
                    if (wr_command && ready) begin
                        phase_reg <= TFR_RUN;
                    end
                end
                TFR_RUN: begin
                    if (finish) begin
                        phase_reg <= TFR_IDLE;
                    end
                end
                TFR_SRST: begin
                    phase_reg <= TFR_IDLE;
                end
                default: begin
                    phase_reg <= TFR_IDLE;
                end
            endcase
        end
    end

    // Start pulse and latched command code toward the core
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            command_reg    <= 8'h00;
            core_cmd_start <= 1'b0;
        end else begin
            core_cmd_start <= wr_command & ready & ~srst_reg;
            if (wr_command) begin
                command_reg <= acc_wdata[7:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Device control
    // -------------------------------------------------------------------
    // High-order select is cleared by any command block write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hob_reg   <= 1'b0;
            srst_reg  <= 1'b0;
            imask_reg <= 1'b0;
        end else if (wr_control) begin
            hob_reg   <= acc_wdata[`TFR_CTL_HOB];
            srst_reg  <= acc_wdata[`TFR_CTL_SRST];
            imask_reg <= acc_wdata[`TFR_CTL_IMASK];
        end else if (wr_cmd_block) begin
            hob_reg <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Address and feature registers
    // -------------------------------------------------------------------
    // Each address or target write pushes the old value into the previous copy
    always_ff @(posedge clock) begin
        if (!rst_n || srst_reg) begin
            feature_reg     <= 8'h00;
            addr0_reg       <= `TFR_ADDR0_RST;
            addr1_reg       <= 8'h00;
            addr2_reg       <= 8'h00;
            target_reg      <= `TFR_TARGET_RST;
            addr0_prev_reg  <= 8'h00;
            addr1_prev_reg  <= 8'h00;
            addr2_prev_reg  <= 8'h00;
            target_prev_reg <= `TFR_TARGET_RST;
        end else if (wr_cmd_block) begin
            unique case (acc_addr)
                `TFR_IDX_ERROR: begin
                    feature_reg <= acc_wdata[7:0];
                end
                `TFR_IDX_ADDR0: begin
                    addr0_prev_reg <= addr0_reg;
                    addr0_reg      <= acc_wdata[7:0];
                end
                `TFR_IDX_ADDR1: begin
                    addr1_prev_reg <= addr1_reg;
                    addr1_reg      <= acc_wdata[7:0];
                end
                `TFR_IDX_ADDR2: begin
                    addr2_prev_reg <= addr2_reg;
                    addr2_reg      <= acc_wdata[7:0];
                end
                `TFR_IDX_TARGET: begin
                    target_prev_reg <= target_reg;
                    // Host keeps the drive number at zero
                    target_reg      <= acc_wdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Transfer count
    // -------------------------------------------------------------------
    // Counts down per sector; zero on success, the remainder on failure
    always_ff @(posedge clock) begin
        if (!rst_n || srst_reg) begin
            count_reg      <= `TFR_COUNT_RST;
            count_prev_reg <= 8'h00;
        end else if (wr_cmd_block && acc_addr == `TFR_IDX_COUNT) begin
            count_prev_reg <= count_reg;
            count_reg      <= acc_wdata[7:0];
        end else if (phase_reg == TFR_RUN) begin
            if (core_cmd_done && !core_cmd_fail) begin
                count_reg <= 8'h00;
            end else if (core_sector_done) begin
                // Zero wraps to 255, so a 256 sector job counts right
                count_reg <= count_reg - 8'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // Error register
    // -------------------------------------------------------------------
    // Cleared at command start, flags gather while the command runs
    always_ff @(posedge clock) begin
        if (!rst_n || srst_reg) begin
            error_reg <= 8'h00;
        end else if (wr_command && !ready) begin
            error_reg <= 8'h00;
            error_reg[`TFR_ERR_ABORTED] <= 1'b1;
        end else if (wr_command) begin
            error_reg <= 8'h00;
        end else if (phase_reg == TFR_RUN) begin
            if (core_bad_block) begin
                error_reg[`TFR_ERR_BAD_BLOCK] <= 1'b1;
            end
            if (core_uncorrectable) begin
                error_reg[`TFR_ERR_UNCORR] <= 1'b1;
            end
            if (core_not_found) begin
                error_reg[`TFR_ERR_NOT_FOUND] <= 1'b1;
            end
            if (core_aborted || core_write_fault) begin
                error_reg[`TFR_ERR_ABORTED] <= 1'b1;
            end
            // Fail with no specific cause falls back to the general flag
            if (core_general_error || (core_cmd_fail && !core_bad_block
                && !core_uncorrectable && !core_not_found
                && !core_aborted && !core_write_fault
                && error_reg == 8'h00)) begin
                error_reg[`TFR_ERR_GENERAL] <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Status flags
    // -------------------------------------------------------------------
    // Error and corrected flags live until the next command is taken
    always_ff @(posedge clock) begin
        if (!rst_n || srst_reg) begin
            err_reg  <= 1'b0;
            corrected_data_flag_reg <= 1'b0;
        end else if (wr_command) begin
            err_reg  <= ~ready;
            corrected_data_flag_reg <= 1'b0;
        end else begin
            if (finish && core_cmd_fail) begin
                err_reg <= 1'b1;
            end
            // Corrected data does not end the command
            if (phase_reg == TFR_RUN && core_corrected) begin
                corrected_data_flag_reg <= 1'b1;
            end
        end
    end

    // Live core conditions sampled into the status and echo bytes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
            drq_reg   <= 1'b0;
            wact_reg  <= 1'b0;
        end else begin
            fault_reg <= core_write_fault;
            drq_reg   <= core_data_request & ~srst_reg;
            wact_reg  <= core_write_active;
        end
    end

    // -------------------------------------------------------------------
    // Interrupt pending
    // -------------------------------------------------------------------
    // Completion beats a status read in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n || srst_reg) begin
            pend_reg <= 1'b0;
        end else if (finish || (wr_command && !ready)) begin
            pend_reg <= 1'b1;
        end else if (rd_state) begin
            pend_reg <= 1'b0;
        end
    end

    assign drive_irq = pend_reg & ~imask_reg;

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    // One cycle of latency; the auxiliary copy leaves pending alone
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_rdata <= 16'h0000;
        end else if (acc_valid && !acc_write) begin
            unique case (acc_addr)
                `TFR_IDX_DATA:   acc_rdata <= core_rd_word;
                `TFR_IDX_ERROR:  acc_rdata <= {8'h00, error_reg};
                `TFR_IDX_COUNT:  acc_rdata <= {8'h00,
                    hob_reg ? count_prev_reg : count_reg};
                `TFR_IDX_ADDR0:  acc_rdata <= {8'h00,
                    hob_reg ? addr0_prev_reg : addr0_reg};
                `TFR_IDX_ADDR1:  acc_rdata <= {8'h00,
                    hob_reg ? addr1_prev_reg : addr1_reg};
                `TFR_IDX_ADDR2:  acc_rdata <= {8'h00,
                    hob_reg ? addr2_prev_reg : addr2_reg};
                `TFR_IDX_TARGET: acc_rdata <= {8'h00,
                    hob_reg ? target_prev_reg : target_reg};
                `TFR_IDX_STATE:  acc_rdata <= {8'h00, state_byte};
                `TFR_IDX_AUX:    acc_rdata <= {8'h00, state_byte};
                `TFR_IDX_ECHO:   acc_rdata <= {8'h00, echo_byte};
                default:         acc_rdata <= 16'h0000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Data register path
    // -------------------------------------------------------------------
    // Words move only while the device asks for them
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            core_rd_take <= 1'b0;
            core_wr_put  <= 1'b0;
            core_wr_word <= 16'h0000;
        end else begin
            core_rd_take <= acc_valid & ~acc_write & drq_reg
                          & (acc_addr == `TFR_IDX_DATA);
            core_wr_put  <= acc_valid & acc_write & drq_reg
                          & (acc_addr == `TFR_IDX_DATA);
            if (acc_valid && acc_write && acc_addr == `TFR_IDX_DATA) begin
                core_wr_word <= acc_wdata;
            end
        end
    end

    // -------------------------------------------------------------------
    // Device-to-host register frame
    // -------------------------------------------------------------------
    // Sent once per completion; carries the values after the update
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
        end else begin
            frame_valid <= finish | (wr_command & ~ready);
        end
    end

    assign frame_status = state_byte;
    assign frame_error  = error_reg;
    assign frame_count  = count_reg;

    // -------------------------------------------------------------------
    // Core-facing decode
    // -------------------------------------------------------------------
    assign core_cmd_code   = command_reg;
    assign core_features   = feature_reg;
    assign core_soft_reset = srst_reg;
    assign core_lba_mode   = target_reg[`TFR_TGT_LBA_MODE];
    // Same bit layout serves CHS: head, cylinder high/low, sector
    assign core_address    = {target_reg[3:0], addr2_reg,
                              addr1_reg, addr0_reg};
    assign core_sector_total = (count_reg == 8'h00) ?
                               `TFR_SECTORS_MAX : {1'b0, count_reg};

endmodule
`default_nettype wire

// file: tb/tfr_task_file_properties.sv
// Port-level assertions for the task file block.
`timescale 1ns/100ps
`default_nettype none
module tfr_task_file_properties (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [3:0]  acc_addr,
    input wire logic [15:0] acc_wdata,
    input wire logic        frame_valid,
    input wire logic [7:0]  frame_status,
    input wire logic [7:0]  frame_error,
    input wire logic [7:0]  frame_count,
    input wire logic        drive_irq,
    input wire logic        core_cmd_start,
    input wire logic [8:0]  core_sector_total,
    input wire logic        core_soft_reset,
    input wire logic        core_ready,
    input wire logic        core_cmd_done,
    input wire logic        core_cmd_fail
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Decoded host accesses
    wire wr_cmd = acc_valid && acc_write && acc_addr == 4'h7;
    wire rd_st  = acc_valid && !acc_write && acc_addr == 4'h7;
    wire rd_aux = acc_valid && !acc_write && acc_addr == 4'h8;
    wire wr_msk = acc_valid && acc_write && acc_addr == 4'h8 && acc_wdata[1];
    // A good end reports an empty count in the next frame
    sequence s_good_end;
        core_cmd_done && !core_cmd_fail && frame_status[7];
    endsequence
    sequence s_idle_report;
        frame_valid && frame_count == 8'h00 && !frame_status[7];
    endsequence
    chk_done_count: assert property (s_good_end |=> s_idle_report)
        else $error("count left after good end");
    chk_start_busy: assert property (core_cmd_start |-> frame_status[7])
        else $error("start while not busy");
    chk_idx_zero: assert property (frame_status[1] == 1'b0)
        else $error("status bit one set");
    chk_err_zero: assert property ((frame_error & 8'h2a) == 8'h00)
        else $error("reserved error bit set");
    chk_count_map: assert property (core_sector_total ==
        ((frame_count == 8'h00) ? 9'h100 : {1'b0, frame_count}))
        else $error("sector total wrong");
    chk_ready_hold: assert property (!core_ready |-> !frame_status[6])
        else $error("ready shown too early");
    chk_srst_busy: assert property (core_soft_reset |-> frame_status[7])
        else $error("soft reset not busy");
    chk_mask_irq: assert property (wr_msk |=> !drive_irq)
        else $error("masked interrupt raised");
    chk_read_clear: assert property (
        rd_st && !core_cmd_done && !core_cmd_fail |=> !drive_irq)
        else $error("status read left interrupt");
    chk_aux_keep: assert property (drive_irq && rd_aux |=> drive_irq)
        else $error("aux read cleared interrupt");
    chk_not_ready: assert property (wr_cmd && !frame_status[7] && !core_ready |=>
        frame_error[2] && frame_status[0] && !core_cmd_start)
        else $error("no abort when not ready");
endmodule
bind tfr_task_file tfr_task_file_properties u_chk (.*);
`default_nettype wire

// file: tb/tfr_core_model.sv
// Behavioural drive core answering commands accepted by the block.
`timescale 1ns/100ps
`default_nettype none
module tfr_core_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       core_cmd_start,
    input  wire logic [8:0] core_sector_total,
    input  wire logic [8:0] fail_at,
    output logic            core_sector_done,
    output logic            core_cmd_done,
    output logic            core_cmd_fail
);
    logic [8:0] left_reg, moved_reg;
    logic       run_reg;
    // One sector a cycle; fail_at ends the job early
    always_ff @(posedge clock) begin
        core_sector_done <= 1'b0;
        core_cmd_done <= 1'b0;
        core_cmd_fail <= 1'b0;
        if (!rst_n) begin
            run_reg <= 1'b0;
        end else if (core_cmd_start) begin
            run_reg <= 1'b1;
            left_reg <= core_sector_total;
            moved_reg <= 9'h000;
        end else if (run_reg && (left_reg == 9'h000 || moved_reg == fail_at)) begin
            run_reg <= 1'b0;
            core_cmd_done <= 1'b1;
            core_cmd_fail <= (left_reg != 9'h000);
        end else if (run_reg) begin
            core_sector_done <= 1'b1;
            left_reg <= left_reg - 9'h001;
            moved_reg <= moved_reg + 9'h001;
        end
    end
endmodule
`default_nettype wire

// file: tb/test_ata_task_file_registers.sv
// Self-checking bench for the task file register block.
`timescale 1ns/100ps
`default_nettype none
module test_ata_task_file_registers;
    import tfr_pkg::*;
    logic clock, rst_n, acc_valid, acc_write, frame_valid, drive_irq, core_cmd_start, pend;
    logic core_lba_mode, core_soft_reset, core_ready, core_sector_done, core_cmd_done;
    logic core_cmd_fail, core_bad_block, core_uncorrectable, core_not_found, core_aborted;
    logic core_general_error, core_corrected, core_write_fault, core_write_active;
    logic core_data_request, core_rd_take, core_wr_put;
    logic [3:0] acc_addr;
    logic [15:0] acc_wdata, acc_rdata, core_rd_word, core_wr_word;
    logic [8:0] core_sector_total, fail_at;
    logic [27:0] core_address;
    logic [31:0] seed;
    logic [4:0] err_flags;
    tfr_byte_t frame_status, frame_error, frame_count, core_cmd_code, core_features;
    logic [15:0] q[$];
    int bad_count, compares, cyc;
    tfr_task_file u_dut (.*);
    tfr_core_model u_core (.*);
    assign {core_bad_block, core_uncorrectable, core_not_found, core_aborted,
            core_general_error} = err_flags;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Drive 1 ns after an edge and hold through the next edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        #1 {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b1, w, a, d};
        @(posedge clock);
        #1 acc_valid = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        q.push_back(e);
        acc(1'b0, a, 16'h0000);
    endtask
    task automatic cmd(input logic [7:0] n, input logic [8:0] f, input logic [4:0] fl);
        int i = 0;
        acc(1'b1, 4'h2, {8'h00, n});
        fail_at = f;
        err_flags = fl;
        acc(1'b1, 4'h7, 16'h0020);
        do begin
            @(posedge clock);
            #1 i++;
        end while (frame_valid !== 1'b1 && i < 60);
        chk(frame_valid, 1);
        err_flags = 5'h00;
    endtask
    // Read data lands a cycle later; the oldest note is its match
    always @(posedge clock) begin
        if (pend) chk(acc_rdata, q.pop_front());
        pend <= acc_valid && !acc_write;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {rst_n, acc_valid, acc_write, acc_addr, acc_wdata, pend, core_rd_word, err_flags} = 0;
        {core_ready, core_corrected, core_write_fault, core_write_active, core_data_request} = 0;
        {bad_count, compares, cyc} = 0;
        seed = 32'd16716;
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        rd(4'h7, 16'h0000);
        rd(4'hf, 16'h0000);
        core_ready = 1'b1;
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            acc(1'b1, 4'h3, seed[15:0]);
            acc(1'b1, 4'h4, seed[23:8]);
            acc(1'b1, 4'h5, seed[31:16]);
            acc(1'b1, 4'h6, {9'h001, k[0], 2'b10, seed[27:24]});
            core_write_active = k[1];
            chk(core_address, seed[27:0]);
            chk(core_lba_mode, k[0]);
            rd(4'h9, {9'h000, ~k[1], ~seed[27:24], 2'b10});
        end
        acc(1'b1, 4'h2, 16'h0000);
        chk(core_sector_total, 9'h100);
        cmd(8'h03, 9'h1ff, 5'h00);
        rd(4'h8, 16'h0050);
        chk(drive_irq, 1);
        rd(4'h2, 16'h0000);
        rd(4'h7, 16'h0050);
        chk(drive_irq, 0);
        core_ready = 1'b0;
        acc(1'b1, 4'h7, 16'h0020);
        rd(4'h1, 16'h0004);
        rd(4'h7, 16'h0001);
        core_ready = 1'b1;
        for (int k = 0; k < 5; k++) begin
            cmd(8'h05, 9'h002, 5'h01 << k);
            rd(4'h1, 16'h0001 << (2 * k - k / 4));
            rd(4'h2, 16'h0003);
            rd(4'h7, 16'h0051);
        end
        acc(1'b1, 4'h2, 16'h0011);
        acc(1'b1, 4'h2, 16'h0022);
        acc(1'b1, 4'h8, 16'h0080);
        rd(4'h2, 16'h0011);
        acc(1'b1, 4'h3, 16'h0001);
        rd(4'h2, 16'h0022);
        acc(1'b1, 4'h8, 16'h0004);
        chk(core_soft_reset, 1);
        acc(1'b1, 4'h8, 16'h0002);
        rd(4'h2, 16'h0001);
        cmd(8'h01, 9'h1ff, 5'h00);
        chk(drive_irq, 0);
        acc(1'b1, 4'h8, 16'h0000);
        chk(drive_irq, 1);
        core_data_request = 1'b1;
        rd(4'h8, 16'h0058);
        acc(1'b1, 4'h0, seed[15:0]);
        chk({core_wr_put, core_wr_word}, {1'b1, seed[15:0]});
        repeat (2) @(posedge clock);
        #1 print_verdict();
    end
endmodule
`default_nettype wire
